// [bench/bmcg_fet_model.sv]
// Model of the external upper and lower power switch pair
`timescale 1ns/100ps
`default_nettype none
module bmcg_fet_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic upper_gate_drive,
  input wire logic lower_gate_drive,
  output logic upper_gs_high,
  output logic lower_gs_high
);
  // Gates discharge over three cycles so the dead time is really waited for
  logic [2:0] up_reg;
  logic [2:0] lo_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      up_reg <= 3'h0;
      lo_reg <= 3'h0;
    end else begin
      up_reg <= {up_reg[1:0], upper_gate_drive};
      lo_reg <= {lo_reg[1:0], lower_gate_drive};
    end
  end
  assign upper_gs_high = |up_reg;
  assign lower_gs_high = |lo_reg;
endmodule // bmcg_fet_model
`default_nettype wire

// [bench/tb_buck_mode_control_gate_sequencer.sv]
// Self-checking bench for the mode controller and gate sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_buck_mode_control_gate_sequencer;
  logic ref_clk = 1'b0, rst_n = 1'b0, lce = 1'b0, pol = 1'b0, dem = 1'b0;
  logic breg = 1'b0, blo = 1'b0, bup = 1'b0, vds = 1'b0, zc = 1'b0;
  logic [7:0] cur = 8'h00;
  logic ug, lg, ugs, lgs, burst, cc;
  logic [7:0] droop;
  int n_mismatch = 0;
  int checks = 0;
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) dem <= ~dem;
  bmcg_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1), .lower_cond_end(lce),
    .phase_node_polarity(pol), .pwm_demand(dem), .below_regulation(breg),
    .below_lower_thr(blo), .above_upper_thr(bup), .lower_vds_positive(vds),
    .upper_gs_high(ugs), .lower_gs_high(lgs), .zero_cross(zc), .phase_current_sample(cur),
    .upper_gate_drive(ug), .lower_gate_drive(lg), .burst_on_request(burst),
    .continuous_conduction(cc), .droop_offset(droop));
  bmcg_fet_model fets (.ref_clk(ref_clk), .rst_n(rst_n), .upper_gate_drive(ug),
    .lower_gate_drive(lg), .upper_gs_high(ugs), .lower_gs_high(lgs));
  // Both gates on together would short the input supply
  always @(negedge ref_clk) if (rst_n && ug === 1'b1 && lg === 1'b1) begin
    n_mismatch++;
    $display("Error gate_overlap expected 0 seen 1");
  end
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic samp(logic p, int n);
    pol = p;
    lce = 1'b1;
    cyc(n);
    lce = 1'b0;
  endtask
  task automatic wcc(logic e, int n);
    for (int i = 0; i < n && cc !== e; i++) cyc(1);
    chk("mode", {7'h00, e}, {7'h00, cc});
  endtask
  task automatic t_enter;
    samp(1'b1, 7);
    samp(1'b0, 1);
    samp(1'b1, 7);
    cyc(4);
    chk("mode", 8'h01, {7'h00, cc});
    samp(1'b1, 1);
    wcc(1'b0, 4);
  endtask
  task automatic t_burst;
    vds = 1'b1;
    blo = 1'b1;
    cyc(4);
    chk("burst", 8'h01, {7'h00, burst});
    chk("lower_gate", 8'h00, {7'h00, lg});
    cyc(6);
    chk("upper_gate", 8'h01, {7'h00, ug});
    blo = 1'b0;
    bup = 1'b1;
    cyc(4);
    chk("burst", 8'h00, {7'h00, burst});
    bup = 1'b0;
    vds = 1'b0;
  endtask
  task automatic t_exit;
    samp(1'b0, 7);
    samp(1'b1, 1);
    samp(1'b0, 7);
    cyc(4);
    chk("mode", 8'h00, {7'h00, cc});
    samp(1'b0, 1);
    wcc(1'b1, 4);
  endtask
  task automatic t_droop;
    cur = 8'h5A;
    zc = 1'b1;
    cyc(1);
    zc = 1'b0;
    cyc(50);
    samp(1'b0, 1);
    cyc(3);
    chk("droop", 8'h5A, droop);
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    cyc(2);
    chk("mode", 8'h01, {7'h00, cc});
    t_enter();
    t_burst();
    breg = 1'b1;
    wcc(1'b1, 4);
    breg = 1'b0;
    samp(1'b1, 8);
    wcc(1'b0, 12);
    t_exit();
    t_droop();
    tally_and_finish();
  end
  initial begin
    #5000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule // tb_buck_mode_control_gate_sequencer
`default_nettype wire

// [rtl/bmcg_current_hold.sv]
// Phase-current sample timer and hold register for the droop offset
`timescale 1ns/100ps
`default_nettype none
module bmcg_current_hold (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic zero_cross,
  input wire logic cycle_end,
  input wire logic [bmcg_pkg::CUR_W-1:0] phase_current_sample,
  output logic [bmcg_pkg::CUR_W-1:0] droop_offset
);
  logic [bmcg_pkg::DLY_W-1:0] dly_reg;
  logic [bmcg_pkg::DLY_W-1:0] dly_next;
  logic arm_reg;
  logic arm_next;
  logic [bmcg_pkg::CUR_W-1:0] held_reg;
  logic [bmcg_pkg::CUR_W-1:0] held_next;
  logic [bmcg_pkg::CUR_W-1:0] droop_reg;
  logic [bmcg_pkg::CUR_W-1:0] droop_next;
  logic take;

  // --------------------------------------------------
  // Sample timing
  // --------------------------------------------------
  assign take = arm_reg && (dly_reg == bmcg_pkg::DLY_W'(bmcg_pkg::SAMPLE_DELAY_CYC - 1));

  always_comb begin
    dly_next = dly_reg;
    arm_next = arm_reg;
    held_next = held_reg;
    droop_next = droop_reg;
    if (zero_cross) begin
      arm_next = 1'b1;
      dly_next = bmcg_pkg::DLY_RESET;
    end else if (take) begin
      arm_next = 1'b0;
      held_next = phase_current_sample;
    end else if (arm_reg) begin
      dly_next = dly_reg + 1'b1;
    end
    // Hold through the cycle; new offset only at the cycle boundary
    if (cycle_end) begin
      droop_next = held_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dly_reg <= bmcg_pkg::DLY_RESET;
      arm_reg <= 1'b0;
      held_reg <= bmcg_pkg::CUR_RESET;
      droop_reg <= bmcg_pkg::CUR_RESET;
    end else if (clk_en) begin
      dly_reg <= dly_next;
      arm_reg <= arm_next;
      held_reg <= held_next;
      droop_reg <= droop_next;
    end
  end

  assign droop_offset = droop_reg;

  // The long wait is checked one step at a time on the counter itself
  chk_sample_delay_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && arm_reg && !zero_cross && !take) |=> (dly_reg == $past(dly_reg) + 1'b1))
    else $error("sample delay counter did not advance");

  chk_sample_take_value: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && take && !zero_cross) |=> (held_reg == $past(phase_current_sample) && !arm_reg))
    else $error("current not captured when the delay ran out");
endmodule // bmcg_current_hold
`default_nettype wire

// [rtl/bmcg_pkg.sv]
// Constants shared by the buck mode controller and gate sequencer
`default_nettype none
package bmcg_pkg;
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned SAMPLE_DELAY_NS = 200;
  localparam int unsigned SAMPLE_DELAY_CYC = (SAMPLE_DELAY_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned FILT_COUNT = 8;
  localparam int unsigned FILT_W = 4;
  localparam int unsigned DLY_W = 6;
  localparam int unsigned CUR_W = 8;
  localparam logic [FILT_W-1:0] FILT_RESET = 4'h0;
  localparam logic [DLY_W-1:0] DLY_RESET = 6'h00;
  localparam logic [CUR_W-1:0] CUR_RESET = 8'h00;
  typedef enum logic [1:0] {
    BMCG_PWM = 2'b00,
    BMCG_HYST = 2'b01,
    BMCG_SWAP = 2'b11
  } bmcg_mode_t;
endpackage : bmcg_pkg
`default_nettype wire

// [rtl/bmcg_sync.sv]
// Two-stage synchroniser for asynchronous comparator inputs
`timescale 1ns/100ps
`default_nettype none
module bmcg_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  always_comb begin
    meta_next = clk_en ? async_in : meta_reg;
    sync_next = clk_en ? meta_reg : sync_reg;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule // bmcg_sync
`default_nettype wire

// [rtl/bmcg_top.sv]
// Mode controller and adaptive dead-time gate sequencer for one buck phase
`timescale 1ns/100ps
`default_nettype none
module bmcg_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic lower_cond_end,
  input wire logic phase_node_polarity,
  input wire logic pwm_demand,
  input wire logic below_regulation,
  input wire logic below_lower_thr,
  input wire logic above_upper_thr,
  input wire logic lower_vds_positive,
  input wire logic upper_gs_high,
  input wire logic lower_gs_high,
  input wire logic zero_cross,
  input wire logic [bmcg_pkg::CUR_W-1:0] phase_current_sample,
  output logic upper_gate_drive,
  output logic lower_gate_drive,
  output logic burst_on_request,
  output logic continuous_conduction,
  output logic [bmcg_pkg::CUR_W-1:0] droop_offset
);
  localparam int unsigned NSYNC = 9;
  localparam logic [bmcg_pkg::FILT_W-1:0] FILT_LAST = bmcg_pkg::FILT_W'(bmcg_pkg::FILT_COUNT - 1);

  // --------------------------------------------------
  // Input synchronisation
  // --------------------------------------------------
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] syn;
  logic s_cond_end;
  logic s_pol;
  logic s_pwm;
  logic s_below_reg;
  logic s_below_lo;
  logic s_above_hi;
  logic s_vds_pos;
  logic s_ugs_high;
  logic s_lgs_high;

  assign raw_in = {lower_cond_end, phase_node_polarity, pwm_demand, below_regulation,
                   below_lower_thr, above_upper_thr, lower_vds_positive, upper_gs_high,
                   lower_gs_high};
  assign {s_cond_end, s_pol, s_pwm, s_below_reg, s_below_lo, s_above_hi, s_vds_pos,
          s_ugs_high, s_lgs_high} = syn;

  bmcg_sync #(.WIDTH(NSYNC)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .async_in(raw_in),
    .sync_out(syn)
  );

  // Zero crossing comes from the phase node edge detector; synchronise it too
  logic s_zero;
  bmcg_sync #(.WIDTH(1)) u_sync_zc (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .async_in(zero_cross),
    .sync_out(s_zero)
  );

  // --------------------------------------------------
  // Mode state and consecutive-sample filter
  // --------------------------------------------------
  bmcg_pkg::bmcg_mode_t mode_reg;
  bmcg_pkg::bmcg_mode_t mode_next;
  logic to_hyst_reg;
  logic to_hyst_next;
  logic [bmcg_pkg::FILT_W-1:0] filt_reg;
  logic [bmcg_pkg::FILT_W-1:0] filt_next;
  logic cc_reg;
  logic cc_next;
  logic sample_valid;
  logic sample_pos;
  logic sample_neg;

  // Mode decode is needed by the mode flag, the burst logic and the gates
  function automatic logic mode_is_hyst(input bmcg_pkg::bmcg_mode_t m);
    mode_is_hyst = (m == bmcg_pkg::BMCG_HYST);
  endfunction

  function automatic logic mode_is_swap(input bmcg_pkg::bmcg_mode_t m);
    mode_is_swap = (m == bmcg_pkg::BMCG_SWAP);
  endfunction

  // A polarity sample exists only while lower conduction is ending
  assign sample_valid = s_cond_end;
  assign sample_pos = sample_valid && s_pol;
  assign sample_neg = sample_valid && !s_pol;

  always_comb begin
    mode_next = mode_reg;
    to_hyst_next = to_hyst_reg;
    filt_next = filt_reg;
    unique case (mode_reg)
      bmcg_pkg::BMCG_PWM: begin
        if (sample_neg) begin
          filt_next = bmcg_pkg::FILT_RESET;
        end else if (sample_pos) begin
          if (filt_reg == FILT_LAST) begin
            mode_next = bmcg_pkg::BMCG_SWAP;
            to_hyst_next = 1'b1;
            filt_next = bmcg_pkg::FILT_RESET;
          end else begin
            filt_next = filt_reg + 1'b1;
          end
        end
      end
      bmcg_pkg::BMCG_HYST: begin
        // A load step must not wait for the filter
        if (s_below_reg) begin
          mode_next = bmcg_pkg::BMCG_SWAP;
          to_hyst_next = 1'b0;
          filt_next = bmcg_pkg::FILT_RESET;
        end else if (sample_pos) begin
          filt_next = bmcg_pkg::FILT_RESET;
        end else if (sample_neg) begin
          if (filt_reg == FILT_LAST) begin
            mode_next = bmcg_pkg::BMCG_SWAP;
            to_hyst_next = 1'b0;
            filt_next = bmcg_pkg::FILT_RESET;
          end else begin
            filt_next = filt_reg + 1'b1;
          end
        end
      end
      bmcg_pkg::BMCG_SWAP: begin
        // One blanking cycle with both switches off, then the new mode
        if (to_hyst_reg) begin
          mode_next = bmcg_pkg::BMCG_HYST;
        end else begin
          mode_next = bmcg_pkg::BMCG_PWM;
        end
        filt_next = bmcg_pkg::FILT_RESET;
      end
      default: begin
        // Unused code: fall back to the safe fixed-frequency mode
        mode_next = bmcg_pkg::BMCG_PWM;
        to_hyst_next = 1'b0;
        filt_next = bmcg_pkg::FILT_RESET;
      end
    endcase
    // Mode flag follows the target at once, so a load step shows next cycle
    cc_next = !(mode_is_hyst(mode_next) || (mode_is_swap(mode_next) && to_hyst_next));
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= bmcg_pkg::BMCG_PWM;
      to_hyst_reg <= 1'b0;
      filt_reg <= bmcg_pkg::FILT_RESET;
      cc_reg <= 1'b1;
    end else if (clk_en) begin
      mode_reg <= mode_next;
      to_hyst_reg <= to_hyst_next;
      filt_reg <= filt_next;
      cc_reg <= cc_next;
    end
  end

  chk_filter_to_hyst: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mode_reg == bmcg_pkg::BMCG_PWM && mode_next == bmcg_pkg::BMCG_SWAP)
      |-> (filt_reg == FILT_LAST && sample_pos))
    else $error("left fixed-frequency mode without eight positive samples");

  chk_filter_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && sample_neg && mode_reg == bmcg_pkg::BMCG_PWM) |=> (filt_reg == '0))
    else $error("filter count kept after an opposite sample");

  // --------------------------------------------------
  // Burst request and gate sequencing
  // --------------------------------------------------
  logic burst_reg;
  logic burst_next;
  logic upper_gate_reg;
  logic upper_gate_next;
  logic lower_gate_reg;
  logic lower_gate_next;
  logic want_upper;
  logic want_lower;
  logic gates_blank;

  always_comb begin
    burst_next = burst_reg;
    if (!(mode_is_hyst(mode_reg) && mode_is_hyst(mode_next))) begin
      burst_next = 1'b0;
    end else if (s_below_lo) begin
      burst_next = 1'b1;
    end else if (s_above_hi) begin
      burst_next = 1'b0;
    end
    gates_blank = mode_is_swap(mode_reg) || mode_is_swap(mode_next);
    if (mode_is_hyst(mode_reg)) begin
      // Error-amplifier demand is ignored while bursting
      want_upper = burst_reg;
      want_lower = !burst_reg && !s_vds_pos;
    end else begin
      want_upper = s_pwm;
      want_lower = !s_pwm;
    end
    // Adaptive dead time: wait for the other gate to be seen discharged
    upper_gate_next = want_upper && !gates_blank && !lower_gate_reg && !s_lgs_high;
    lower_gate_next = want_lower && !gates_blank && !upper_gate_reg && !s_ugs_high;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_reg <= 1'b0;
      upper_gate_reg <= 1'b0;
      lower_gate_reg <= 1'b0;
    end else if (clk_en) begin
      burst_reg <= burst_next;
      upper_gate_reg <= upper_gate_next;
      lower_gate_reg <= lower_gate_next;
    end
  end

  chk_gates_exclusive: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(upper_gate_reg && lower_gate_reg))
    else $error("both gate drives on together");

  chk_upper_dead_time: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && upper_gate_next && !upper_gate_reg) |-> !s_lgs_high)
    else $error("upper gate raised while lower gate still charged");

  chk_lower_dead_time: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (clk_en && lower_gate_next && !lower_gate_reg) |-> !s_ugs_high)
    else $error("lower gate raised while upper gate still charged");

  chk_swap_gates_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mode_reg == bmcg_pkg::BMCG_SWAP) |-> (!upper_gate_reg && !lower_gate_reg))
    else $error("gate drive on during a mode change");

  chk_burst_only_hyst: assert property (@(posedge ref_clk) disable iff (!rst_n)
    burst_reg |-> (mode_reg == bmcg_pkg::BMCG_HYST))
    else $error("burst request outside hysteretic mode");

  // --------------------------------------------------
  // Phase-current sample and droop hold
  // --------------------------------------------------
  bmcg_current_hold u_hold (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .zero_cross(s_zero),
    .cycle_end(s_cond_end),
    .phase_current_sample(phase_current_sample),
    .droop_offset(droop_offset)
  );

  // --------------------------------------------------
  // Outputs
  // --------------------------------------------------
  assign upper_gate_drive = upper_gate_reg;
  assign lower_gate_drive = lower_gate_reg;
  assign burst_on_request = burst_reg;
  assign continuous_conduction = cc_reg;
endmodule // bmcg_top
`default_nettype wire
